// File: inc/sadc_pkg.sv
// Shared constants, types and register map of the SAR converter sequencer
package sadc_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses on the Avalon-MM slave)
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W       = 3;
   localparam logic [2:0]  OFS_CTRL     = 3'h0;
   localparam logic [2:0]  OFS_RESULT   = 3'h4;
   localparam int unsigned DATA_W       = 32;
   localparam int unsigned BE_W         = 4;
   localparam int unsigned CTRL_BE_LANE = 0;

   // ---------------------------------------------------------------
   // Control register fields and reset value
   // ---------------------------------------------------------------
   localparam int unsigned SEL_W        = 3;
   localparam int unsigned SEL_EXT_W    = 2;
   localparam int unsigned SEL_INT_BIT  = 2;
   localparam int unsigned FLAG_BIT     = 7;
   localparam int unsigned REG_W        = 8;
   localparam logic [2:0]  SEL_RST      = 3'h0;
   localparam logic [7:0]  RESULT_RST   = 8'h00;

   // Internal calibration channel codes and their ideal conversions
   localparam logic [2:0]  SEL_HIGH_REF = 3'h4;
   localparam logic [2:0]  SEL_LOW_REF  = 3'h5;
   localparam logic [2:0]  SEL_QTR_REF  = 3'h6;
   localparam logic [2:0]  SEL_HALF_REF = 3'h7;
   localparam logic [7:0]  CODE_HIGH    = 8'hFF;
   localparam logic [7:0]  CODE_LOW     = 8'h00;
   localparam logic [7:0]  CODE_QTR     = 8'h40;
   localparam logic [7:0]  CODE_HALF    = 8'h80;

   // ---------------------------------------------------------------
   // Conversion timing, in machine cycles (clock-enable cycles)
   // ---------------------------------------------------------------
   localparam logic [4:0]  CONV_CYCLES   = 5'h1E;
   localparam logic [4:0]  SAMPLE_CYCLES = 5'h05;
   localparam logic [4:0]  LAST_CYCLE    = 5'(CONV_CYCLES - 5'h01);
   localparam logic [4:0]  LAST_SAMPLE   = 5'(SAMPLE_CYCLES - 5'h01);
   localparam logic [1:0]  DECIDE_SUB    = 2'h2;
   localparam logic [2:0]  MSB_IDX       = 3'h7;
   localparam logic [2:0]  LSB_IDX       = 3'h0;
   localparam logic [7:0]  SAR_SEED      = 8'h80;

   typedef enum logic [1:0] {
      ST_SAMPLE,
      ST_TRIAL,
      ST_FINISH
   } sadc_state_t;

   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [2:0]        addr;
      logic [3:0]        be;
      logic [31:0]       wdata;
   } sadc_bus_req_t;

endpackage : sadc_pkg

// File: rtl/sadc_sar_core.sv
// Successive-approximation register: trial code and bit decisions
`timescale 1ns/1ps
module sadc_sar_core (
   input  wire logic       mclk_in,
   input  wire logic       rst_n_in,
   input  wire logic       ce_in,
   input  wire logic       start_in,
   input  wire logic       decide_in,
   input  wire logic       keep_in,
   input  wire logic [2:0] bit_idx_in,
   output logic      [7:0] code_out
);

   logic [7:0] code_ff;
   logic [7:0] nxt_code;

   // ---------------------------------------------------------------
   // Trial code update
   // ---------------------------------------------------------------
   always_comb begin
      nxt_code = code_ff;
      if (start_in) begin
         nxt_code = sadc_pkg::SAR_SEED;
      end else if (decide_in) begin
         // Keep or drop the bit under trial, then try the next lower one
         nxt_code[bit_idx_in] = keep_in;
         if (bit_idx_in != sadc_pkg::LSB_IDX) begin
            nxt_code[3'(bit_idx_in - 3'h1)] = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         code_ff <= sadc_pkg::RESULT_RST;
      end else if (ce_in) begin
         code_ff <= nxt_code;
      end
   end

   assign code_out = code_ff;

endmodule : sadc_sar_core

// File: rtl/sadc_sequencer.sv
// Control, sequencing and register slave of the 8-bit SAR converter
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sadc_sequencer (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ce_in,
   input  wire logic [2:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic        cmp_above_in,
   output logic      [1:0]  chan_sel_out,
   output logic             track_out,
   output logic      [7:0]  dac_code_out
);

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   function automatic logic sadc_hit(input logic [2:0] addr, input logic [2:0] ofs);
      sadc_hit = (addr == ofs);
   endfunction : sadc_hit

   // Ideal code of an internal calibration channel
   function automatic logic [7:0] sadc_ref_code(input logic [2:0] sel);
      unique case (sel)
         sadc_pkg::SEL_HIGH_REF: sadc_ref_code = sadc_pkg::CODE_HIGH;
         sadc_pkg::SEL_LOW_REF:  sadc_ref_code = sadc_pkg::CODE_LOW;
         sadc_pkg::SEL_QTR_REF:  sadc_ref_code = sadc_pkg::CODE_QTR;
         default:                sadc_ref_code = sadc_pkg::CODE_HALF;
      endcase
   endfunction : sadc_ref_code

   sadc_pkg::sadc_bus_req_t req;

   logic        waitreq_ff;
   logic        nxt_waitreq;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic        wr_acc;
   logic        rd_cap;
   logic        res_rd_now;

   logic [2:0]  sel_ff;
   logic [2:0]  nxt_sel;
   logic        flag_ff;
   logic        nxt_flag;
   logic [7:0]  result_ff;
   logic [7:0]  nxt_result;
   logic        pend_ff;
   logic        nxt_pend;
   logic [7:0]  pend_val_ff;
   logic [7:0]  nxt_pend_val;

   sadc_pkg::sadc_state_t state_ff;
   sadc_pkg::sadc_state_t nxt_state;
   logic [4:0]  cnt_ff;
   logic [4:0]  nxt_cnt;
   logic [1:0]  sub_ff;
   logic [1:0]  nxt_sub;
   logic [2:0]  bit_ff;
   logic [2:0]  nxt_bit;
   logic        sar_start;
   logic        sar_decide;
   logic        keep;
   logic        done_ev;
   logic [7:0]  code;

   logic        cmp_s1_ff;
   logic        cmp_s2_ff;
   logic [1:0]  chan_ff;
   logic        track_ff;

   assign req = '{rd:    avs_read_in,
                  wr:    avs_write_in,
                  addr:  avs_address_in,
                  be:    avs_byteenable_in,
                  wdata: avs_writedata_in};

   // ---------------------------------------------------------------
   // Avalon-MM slave: one wait state on every access
   // ---------------------------------------------------------------
   always_comb begin
      wr_acc      = ce_in && req.wr && !waitreq_ff && req.be[sadc_pkg::CTRL_BE_LANE]
                    && sadc_hit(req.addr, sadc_pkg::OFS_CTRL);
      rd_cap      = ce_in && req.rd && waitreq_ff;
      res_rd_now  = rd_cap && sadc_hit(req.addr, sadc_pkg::OFS_RESULT);
      nxt_waitreq = !((req.rd || req.wr) && waitreq_ff);
      nxt_rdata   = rdata_ff;
      if (rd_cap) begin
         if (sadc_hit(req.addr, sadc_pkg::OFS_CTRL)) begin
            nxt_rdata = '0;
            nxt_rdata[sadc_pkg::FLAG_BIT] = flag_ff;
            nxt_rdata[sadc_pkg::SEL_W-1:0] = sel_ff;
         end else if (sadc_hit(req.addr, sadc_pkg::OFS_RESULT)) begin
            nxt_rdata = 32'(result_ff);
         end else begin
            nxt_rdata = '0;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         waitreq_ff <= 1'b1;
         rdata_ff   <= '0;
      end else if (ce_in) begin
         waitreq_ff <= nxt_waitreq;
         rdata_ff   <= nxt_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Control and result registers
   // ---------------------------------------------------------------
   always_comb begin
      nxt_sel      = sel_ff;
      nxt_flag     = flag_ff;
      nxt_result   = result_ff;
      nxt_pend     = pend_ff;
      nxt_pend_val = pend_val_ff;
      if (wr_acc) begin
         nxt_sel  = req.wdata[sadc_pkg::SEL_W-1:0];
         nxt_flag = 1'b0;
      end
      // Completion wins over a clearing write in the same cycle
      if (done_ev) begin
         nxt_flag = 1'b1;
      end
      // A result read being captured this cycle defers the load by one
      if (done_ev && !res_rd_now) begin
         nxt_result = code;
         nxt_pend   = 1'b0;
      end else if (done_ev) begin
         nxt_pend     = 1'b1;
         nxt_pend_val = code;
      end else if (pend_ff && !res_rd_now) begin
         nxt_result = pend_val_ff;
         nxt_pend   = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sel_ff      <= sadc_pkg::SEL_RST;
         flag_ff     <= 1'b0;
         result_ff   <= sadc_pkg::RESULT_RST;
         pend_ff     <= 1'b0;
         pend_val_ff <= sadc_pkg::RESULT_RST;
      end else if (ce_in) begin
         sel_ff      <= nxt_sel;
         flag_ff     <= nxt_flag;
         result_ff   <= nxt_result;
         pend_ff     <= nxt_pend;
         pend_val_ff <= nxt_pend_val;
      end
   end

   // ---------------------------------------------------------------
   // Conversion sequencer
   // ---------------------------------------------------------------
   // Calibration channels are decided against their ideal code, so no
   // comparator noise reaches them; saturation to all ones needs no logic.
   assign keep = sel_ff[sadc_pkg::SEL_INT_BIT] ? (sadc_ref_code(sel_ff) >= code)
                                               : cmp_s2_ff;

   always_comb begin
      nxt_state  = state_ff;
      nxt_cnt    = cnt_ff;
      nxt_sub    = sub_ff;
      nxt_bit    = bit_ff;
      sar_start  = 1'b0;
      sar_decide = 1'b0;
      done_ev    = 1'b0;
      if (state_ff == sadc_pkg::ST_FINISH) begin
         done_ev = ce_in;
      end
      if (wr_acc) begin
         nxt_state = sadc_pkg::ST_SAMPLE;
         nxt_cnt   = '0;
      end else begin
         unique case (state_ff)
            sadc_pkg::ST_SAMPLE: begin
               nxt_cnt = 5'(cnt_ff + 5'h01);
               if (cnt_ff == sadc_pkg::LAST_SAMPLE) begin
                  nxt_state = sadc_pkg::ST_TRIAL;
                  nxt_sub   = '0;
                  nxt_bit   = sadc_pkg::MSB_IDX;
                  sar_start = ce_in;
               end
            end
            sadc_pkg::ST_TRIAL: begin
               nxt_cnt = 5'(cnt_ff + 5'h01);
               nxt_sub = 2'(sub_ff + 2'h1);
               // Two cycles let the comparator answer pass the synchroniser
               if (sub_ff == sadc_pkg::DECIDE_SUB) begin
                  sar_decide = ce_in;
                  nxt_sub    = '0;
                  if (bit_ff == sadc_pkg::LSB_IDX) begin
                     nxt_state = sadc_pkg::ST_FINISH;
                  end else begin
                     nxt_bit = 3'(bit_ff - 3'h1);
                  end
               end
            end
            sadc_pkg::ST_FINISH: begin
               nxt_state = sadc_pkg::ST_SAMPLE;
               nxt_cnt   = '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff  <= sadc_pkg::ST_SAMPLE;
         cnt_ff    <= '0;
         sub_ff    <= '0;
         bit_ff    <= sadc_pkg::MSB_IDX;
         cmp_s1_ff <= 1'b0;
         cmp_s2_ff <= 1'b0;
         chan_ff   <= '0;
         track_ff  <= 1'b1;
      end else if (ce_in) begin
         state_ff  <= nxt_state;
         cnt_ff    <= nxt_cnt;
         sub_ff    <= nxt_sub;
         bit_ff    <= nxt_bit;
         cmp_s1_ff <= cmp_above_in;
         cmp_s2_ff <= cmp_s1_ff;
         chan_ff   <= nxt_sel[sadc_pkg::SEL_EXT_W-1:0];
         track_ff  <= (nxt_state == sadc_pkg::ST_SAMPLE);
      end
   end

   sadc_sar_core u_sar (
      .mclk_in    (mclk_in),
      .rst_n_in   (rst_n_in),
      .ce_in      (ce_in),
      .start_in   (sar_start),
      .decide_in  (sar_decide),
      .keep_in    (keep),
      .bit_idx_in (bit_ff),
      .code_out   (code)
   );

   assign avs_readdata_out    = rdata_ff;
   assign avs_waitrequest_out = waitreq_ff;
   assign chan_sel_out        = chan_ff;
   assign track_out           = track_ff;
   assign dac_code_out        = code;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [4:0] len_ff;

   // Machine cycles since the conversion began, independent of cnt_ff
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         len_ff <= '0;
      end else if (ce_in) begin
         len_ff <= (wr_acc || done_ev) ? 5'h00 : 5'(len_ff + 5'h01);
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_write_taken;
      wr_acc;
   endsequence

   sequence s_sample_run;
      s_write_taken ##1 (ce_in && !wr_acc)[*5];
   endsequence

   sel_write_a: assert property (s_write_taken |=> sel_ff == $past(req.wdata[2:0]))
      else $error("select field not loaded by control write");

   abort_restart_a: assert property (s_write_taken |=> track_ff && len_ff == 5'h00)
      else $error("control write did not restart sampling");

   flag_clear_a: assert property (wr_acc && !done_ev |=> !flag_ff)
      else $error("completion flag survived a control write");

   sample_hold_a: assert property (s_write_taken |=> track_ff[*5])
      else $error("sampling period cut short after control write");

   sample_len_a: assert property (s_sample_run |=> !track_ff)
      else $error("sampling period longer than five cycles");

   conv_len_a: assert property (done_ev |-> len_ff == sadc_pkg::LAST_CYCLE)
      else $error("conversion length differs from thirty cycles");

   result_load_a: assert property (done_ev && !res_rd_now
                                   |=> result_ff == $past(code) && flag_ff)
      else $error("result or flag not updated at completion");

   restart_a: assert property (done_ev && !wr_acc |=> track_ff ##1 !ce_in || track_ff)
      else $error("no automatic restart after completion");

   read_stable_a: assert property (res_rd_now |=> $stable(result_ff))
      else $error("result changed while being read");

   cal_code_a: assert property (done_ev && sel_ff[2] |-> code == sadc_ref_code(sel_ff))
      else $error("calibration channel gave wrong code");

   flag_sticky_a: assert property (flag_ff && !wr_acc |=> flag_ff)
      else $error("completion flag dropped without a write");

endmodule : sadc_sequencer

// File: test/sadc_analog_src.sv
// Analog source model: port-pin levels, sample-and-hold and comparator
`timescale 1ns/1ps
module sadc_analog_src (
   input  wire logic            mclk_in,
   input  wire logic [1:0]      chan_sel_in,
   input  wire logic            track_in,
   input  wire logic [7:0]      dac_code_in,
   input  wire logic [3:0][8:0] level_in,
   output logic                 cmp_above_out
);
   logic [8:0] held_ff;

   // Tracks only while the converter samples, so a late level change is not seen
   always_ff @(posedge mclk_in) begin
      if (track_in) begin
         held_ff <= level_in[chan_sel_in];
      end
   end

   // Levels past full scale stay above every trial code
   assign cmp_above_out = (held_ff >= {1'h0, dac_code_in});
endmodule : sadc_analog_src

// File: test/sadc_sequencer_test.sv
// Self-checking bench of the SAR converter sequencer
`timescale 1ns/1ps
module sadc_sequencer_test;
   logic            mclk_in = 1'h0;
   logic            rst_n_in = 1'h0;
   logic [2:0]      addr = 3'h0;
   logic            rd = 1'h0;
   logic            wr = 1'h0;
   logic [31:0]     wdata = 32'h0;
   logic [3:0]      be = 4'h0;
   logic [31:0]     rdata;
   logic            waitreq;
   logic            cmp;
   logic [1:0]      chan;
   logic            track;
   logic [7:0]      dac;
   logic [3:0][8:0] lvl = '0;
   logic            ce = 1'h1;
   logic            ce_old;
   logic [7:0]      dac_old;
   int              n_errors = 0;
   int              checks = 0;
   logic [31:0]     seen;
   logic [2:0]      sel;

   always #2.5 mclk_in = ~mclk_in;

   sadc_sequencer i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
      .avs_waitrequest_out(waitreq), .cmp_above_in(cmp), .chan_sel_out(chan),
      .track_out(track), .dac_code_out(dac));

   sadc_analog_src i_src (.mclk_in(mclk_in), .chan_sel_in(chan), .track_in(track),
      .dac_code_in(dac), .level_in(lvl), .cmp_above_out(cmp));

   // ------------------------------------------------------------
   // Expectations and reporting
   // ------------------------------------------------------------
   function automatic logic [7:0] exp_code(input logic [2:0] s, input logic [3:0][8:0] l);
      case (s)
         3'h4: return 8'hFF;
         3'h5: return 8'h00;
         3'h6: return 8'h40;
         3'h7: return 8'h80;
         default: return (l[s[1:0]] > 9'h0FF) ? 8'hFF : l[s[1:0]][7:0];
      endcase
   endfunction : exp_code

   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, s, e);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   // ------------------------------------------------------------
   // Avalon master: hold the request until waitrequest is seen low
   // ------------------------------------------------------------
   task automatic acc(input logic w, input logic [2:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge mclk_in);
      addr <= a;
      rd <= ~w;
      wr <= w;
      wdata <= d;
      be <= b;
      do begin
         @(posedge mclk_in);
         n++;
      end while (waitreq !== 1'h0 && n < 100);
      check({31'h0, waitreq}, 32'h0);
      r = rdata;
      rd <= 1'h0;
      wr <= 1'h0;
   endtask : acc

   task automatic wr_ctrl(input logic [2:0] s);
      logic [31:0] d;
      logic [31:0] r;
      d = $urandom();
      d[2:0] = s;
      acc(1'h1, 3'h0, d, 4'hF, r);
   endtask : wr_ctrl

   task automatic wait_flag();
      int n;
      n = 0;
      do begin
         acc(1'h0, 3'h0, 32'h0, 4'hF, seen);
         n++;
      end while (seen[7] !== 1'h1 && n < 40);
      check({31'h0, seen[7]}, 32'h1);
   endtask : wait_flag

   // Sampling length and conversion length seen on the track output
   task automatic measure_track();
      int hi;
      int lo;
      repeat (2) begin
         hi = 0;
         lo = 0;
         while (track === 1'h1 && hi < 40) begin
            hi++;
            @(negedge mclk_in);
         end
         while (track === 1'h0 && lo < 40) begin
            lo++;
            @(negedge mclk_in);
         end
         check(hi, 32'h5);
         check(hi + lo, 32'h1E);
      end
   endtask : measure_track

   initial begin
      #300000;
      n_errors++;
      end_of_test();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'hBD515459));
      repeat (8) @(posedge mclk_in);
      rst_n_in <= 1'h1;
      acc(1'h0, 3'h0, 32'h0, 4'hF, seen);
      check(seen, 32'h0);
      acc(1'h0, 3'h2, 32'h0, 4'hF, seen);
      check(seen, 32'h0);
      acc(1'h1, 3'h4, 32'hFF, 4'hF, seen);
      acc(1'h0, 3'h4, 32'h0, 4'hF, seen);
      check(seen, 32'h0);
      acc(1'h1, 3'h0, 32'h7, 4'hE, seen);
      acc(1'h0, 3'h0, 32'h0, 4'hF, seen);
      check(seen & 32'h7F, 32'h0);
      // Every select code, then random ones; some levels above full scale
      for (int i = 0; i < 14; i++) begin
         sel = (i < 8) ? i[2:0] : 3'($urandom_range(7));
         @(posedge mclk_in);
         for (int k = 0; k < 4; k++) begin
            lvl[k] <= (i == 1 && k == 1) ? 9'h1FF : 9'($urandom_range(320));
         end
         wr_ctrl(sel);
         // The select output is launched at the accepting edge; look once it has settled
         @(negedge mclk_in);
         if (!sel[2]) check({30'h0, chan}, {30'h0, sel[1:0]});
         if (i == 0) begin
            measure_track();
         end else begin
            acc(1'h0, 3'h0, 32'h0, 4'hF, seen);
            check(seen, {29'h0, sel});
         end
         wait_flag();
         acc(1'h0, 3'h4, 32'h0, 4'hF, seen);
         check(seen, {24'h0, exp_code(sel, lvl)});
      end
      // Abort in mid-conversion, then a sticky flag across conversions
      @(posedge mclk_in);
      lvl <= {9'h000, 9'h0CC, 9'h033, 9'h000};
      wr_ctrl(3'h1);
      repeat (12) @(posedge mclk_in);
      wr_ctrl(3'h2);
      acc(1'h0, 3'h0, 32'h0, 4'hF, seen);
      check(seen, 32'h2);
      wait_flag();
      acc(1'h0, 3'h4, 32'h0, 4'hF, seen);
      check(seen, 32'hCC);
      // Random clock-enable gaps: a clock cycle with enable low must freeze the trial code
      for (int c = 0; c < 120; c++) begin
         @(posedge mclk_in);
         if (c > 0 && ce_old === 1'h0) check({24'h0, dac}, {24'h0, dac_old});
         dac_old = dac;
         ce_old = ce;
         ce <= 1'($urandom_range(1));
      end
      @(posedge mclk_in);
      ce <= 1'h1;
      acc(1'h0, 3'h0, 32'h0, 4'hF, seen);
      check(seen, 32'h82);
      acc(1'h0, 3'h4, 32'h0, 4'hF, seen);
      check(seen, 32'hCC);
      // Second reset in mid-run
      @(posedge mclk_in);
      rst_n_in <= 1'h0;
      repeat (3) @(posedge mclk_in);
      rst_n_in <= 1'h1;
      acc(1'h0, 3'h0, 32'h0, 4'hF, seen);
      check(seen, 32'h0);
      end_of_test();
   end
endmodule : sadc_sequencer_test
